// ### cap_array_props.sv
`timescale 1ns/1ps
`include "cap_map.svh"
// Port checker for the counter array
module cap_array_props #(
  parameter int NUM_MODULES = 5
) (
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [7:0] rdata_out,
  input wire logic timer_ovf_in,
  input wire logic ext_count_pin_in,
  input wire logic [NUM_MODULES-1:0] module_output_pin_out,
  input wire logic irq_out,
  input wire logic wd_reset_out
);
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!reset_n_in);
  logic run_on; // Shadow of run bit
  logic wd_armed; // Shadow of watchdog enable
  logic [1:0] mask_lo; // Shadow of irq mask
  logic [3:0] quiet; // Idle cycles without writes or run
  // Shadows follow software writes
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      run_on <= 1'b0;
      wd_armed <= 1'b0;
      mask_lo <= 2'h0;
      quiet <= 4'h0;
    end else begin
      if (wr_in && addr_in == `CAP_ADDR_CTRL) run_on <= wdata_in[`CAP_CTRL_RUN];
      if (wr_in && addr_in == `CAP_ADDR_COUNTER_MODE_REG) wd_armed <= wdata_in[`CAP_COUNTER_MODE_REG_WATCHDOG_ENABLE_BIT];
      if (wr_in && addr_in == `CAP_ADDR_IRQ_MASK) mask_lo <= wdata_in[1:0];
      quiet <= (wr_in || run_on) ? 4'h0 : ((quiet == 4'hF) ? 4'hF : quiet + 4'h1);
    end
  end
  reset_quiet_a: assert property ($rose(reset_n_in) |->
    module_output_pin_out == '0 && !irq_out && !wd_reset_out) else $error("outputs not idle");
  rd_idle_a: assert property (!$past(rd_in) |-> rdata_out == 8'h00)
    else $error("read data outside read slot");
  unmapped_read_a: assert property (rd_in && addr_in == 8'h00 |=> rdata_out == 8'h00)
    else $error("unmapped read not zero");
  mask_readback_a: assert property (rd_in && addr_in == `CAP_ADDR_IRQ_MASK |=>
    rdata_out[1:0] == mask_lo) else $error("mask readback wrong");
  mask_off_a: assert property ((mask_lo == 2'h0) [*3] |-> !irq_out)
    else $error("irq while masked");
  wd_pulse_a: assert property ($rose(wd_reset_out) |->
    wd_reset_out [*4] ##1 !wd_reset_out) else $error("reset pulse width wrong");
  wd_armed_a: assert property ($rose(wd_reset_out) |-> wd_armed)
    else $error("reset while watchdog off");
  run_stop_a: assert property (quiet >= 4'h3 |-> $stable(module_output_pin_out))
    else $error("pins moved while stopped");
  cover property ($rose(wd_reset_out));
  cover property ($rose(irq_out));
  cover property ($changed(module_output_pin_out));
endmodule
bind cap_counter_array cap_array_props #(.NUM_MODULES(NUM_MODULES)) cap_array_props_inst (
  .sys_clk_in, .reset_n_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out, .timer_ovf_in,
  .ext_count_pin_in, .module_output_pin_out, .irq_out, .wd_reset_out);

// ### cap_counter_array.sv
`timescale 1ns/1ps
`include "cap_map.svh"
module cap_counter_array
  import cap_pkg::*;
#(
  parameter int NUM_MODULES = 5
) (
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  input wire logic timer_ovf_in,
  input wire logic ext_count_pin_in,
  output logic [NUM_MODULES-1:0] module_output_pin_out,
  output logic irq_out,
  output logic wd_reset_out
);
  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic ovf; // Counter overflow flag
    logic run; // Counter run bit
    logic [NUM_MODULES-1:0] flags; // Module match flags
    logic [7:0] counter_mode_reg; // Counter mode register
    logic [NUM_MODULES-1:0][7:0] mode; // Module mode registers
    logic [NUM_MODULES-1:0][7:0] reload; // Duty reload / compare high
    logic [15:0] count; // Shared counter
    logic [7:0] rdata; // Read data
    logic [1:0] stat; // Sticky irq status: ovf, match
    logic [1:0] mask; // Irq mask
    logic [2:0] wd_cnt; // Reset pulse stretcher
  } cap_state_t;
  cap_state_t st;
  cap_state_t next_st;
  logic step;
  logic [15:0] next_count;
  logic [NUM_MODULES-1:0] match;
  logic [NUM_MODULES-1:0][7:0] duty;
  logic [NUM_MODULES-1:0] duty_wr;
  logic [NUM_MODULES-1:0] flag_irq;
  logic wd_fire;
  // Module index from an address, or all ones when out of range
  function automatic logic [7:0] mod_index(input logic [7:0] a, input logic [7:0] base);
    logic [7:0] d;
    d = 8'(a - base);
    mod_index = (d < 8'(NUM_MODULES)) ? d : 8'hFF;
  endfunction
  // ****************************************
  // Count pulse source
  // ****************************************
  cap_pulse_gen u_pulse (
    .sys_clk_in(sys_clk_in),
    .reset_n_in(reset_n_in),
    .src_in(cap_src_t'(st.counter_mode_reg[2:1])),
    .timer_ovf_in(timer_ovf_in),
    .ext_pin_in(ext_count_pin_in),
    .pulse_out(step)
  );
  logic step_gated; // Count pulse gated by the run bit
  // Counter advances on pulse while running
  always_comb begin
    step_gated = st.run && step;
  end
  assign next_count = 16'(st.count + 16'h0001);
  // ****************************************
  // Compare modules
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < NUM_MODULES; g++) begin : gen_mod
      assign duty_wr[g] = wr_in && (mod_index(addr_in, `CAP_ADDR_DLO0) == 8'(g));
      cap_module u_mod (
        .sys_clk_in(sys_clk_in),
        .reset_n_in(reset_n_in),
        .mode_in(st.mode[g]),
        .count_in(st.count),
        .next_count_in(next_count),
        .step_in(step_gated),
        .reload_in(st.reload[g]),
        .wr_active_in(duty_wr[g]),
        .wdata_in(wdata_in),
        .match_out(match[g]),
        .active_duty_out(duty[g]),
        .pin_out(module_output_pin_out[g])
      );
      // Flag raises irq when enabled
      assign flag_irq[g] = st.flags[g] && st.mode[g][`CAP_MODE_IE];
    end
  endgenerate
  // Watchdog only on module four, gated by its enable
  assign wd_fire = match[`CAP_WD_MODULE] && st.counter_mode_reg[`CAP_COUNTER_MODE_REG_WATCHDOG_ENABLE_BIT];
  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    logic [7:0] idx;
    idx = 8'h00;
    next_st = st;
    if (step_gated) begin
      next_st.count = next_count;
    end
    // Watchdog reset pulse, no pin driven
    if (wd_fire) begin
      next_st.wd_cnt = 3'(`CAP_WD_PULSE_CYC);
    end else if (st.wd_cnt != 3'h0) begin
      next_st.wd_cnt = 3'(st.wd_cnt - 3'h1);
    end
    // Read data, one cycle later
    next_st.rdata = 8'h00;
    if (rd_in) begin
      if (addr_in == `CAP_ADDR_CTRL) begin
        next_st.rdata = {st.ovf, st.run, 1'b0, 5'(st.flags)};
      end else if (addr_in == `CAP_ADDR_COUNTER_MODE_REG) begin
        next_st.rdata = st.counter_mode_reg;
      end else if (addr_in == `CAP_ADDR_CNT_LO) begin
        next_st.rdata = st.count[7:0];
      end else if (addr_in == `CAP_ADDR_CNT_HI) begin
        next_st.rdata = st.count[15:8];
      end else if (addr_in == `CAP_ADDR_IRQ_STAT) begin
        next_st.rdata = {6'h00, st.stat};
        next_st.stat = 2'h0;
      end else if (addr_in == `CAP_ADDR_IRQ_MASK) begin
        next_st.rdata = {6'h00, st.mask};
      end else begin
        idx = mod_index(addr_in, `CAP_ADDR_MODE0);
        if (idx != 8'hFF) begin
          next_st.rdata = st.mode[idx[2:0]];
        end
        idx = mod_index(addr_in, `CAP_ADDR_DLO0);
        if (idx != 8'hFF) begin
          next_st.rdata = duty[idx[2:0]];
        end
        idx = mod_index(addr_in, `CAP_ADDR_DHI0);
        if (idx != 8'hFF) begin
          next_st.rdata = st.reload[idx[2:0]];
        end
      end
    end
    // Register writes
    if (wr_in) begin
      if (addr_in == `CAP_ADDR_CTRL) begin
        next_st.ovf = wdata_in[`CAP_CTRL_OVF];
        next_st.run = wdata_in[`CAP_CTRL_RUN];
        next_st.flags = wdata_in[NUM_MODULES-1:0];
      end else if (addr_in == `CAP_ADDR_COUNTER_MODE_REG) begin
        next_st.counter_mode_reg = wdata_in;
      end else if (addr_in == `CAP_ADDR_CNT_LO) begin
        next_st.count[7:0] = wdata_in;
      end else if (addr_in == `CAP_ADDR_CNT_HI) begin
        next_st.count[15:8] = wdata_in;
      end else if (addr_in == `CAP_ADDR_IRQ_MASK) begin
        next_st.mask = wdata_in[1:0];
      end else begin
        idx = mod_index(addr_in, `CAP_ADDR_MODE0);
        if (idx != 8'hFF) begin
          next_st.mode[idx[2:0]] = wdata_in;
        end
        idx = mod_index(addr_in, `CAP_ADDR_DHI0);
        if (idx != 8'hFF) begin
          next_st.reload[idx[2:0]] = wdata_in;
        end
      end
    end
    // Hardware sets win over software clears
    next_st.flags = next_st.flags | match;
    if (step_gated && st.count == 16'hFFFF) begin
      next_st.ovf = 1'b1;
    end
    // Sticky irq events
    if (st.ovf && st.counter_mode_reg[`CAP_COUNTER_MODE_REG_OVF_IE]) begin
      next_st.stat[1] = 1'b1;
    end
    if (|flag_irq) begin
      next_st.stat[0] = 1'b1;
    end
  end
  assign irq_out = |(st.stat & st.mask);
  assign rdata_out = st.rdata;
  assign wd_reset_out = (st.wd_cnt != 3'h0);
  // Register, everything cleared on reset
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
endmodule

// ### cap_counter_array_bench.sv
`timescale 1ns/1ps
`include "cap_map.svh"
module cap_counter_array_bench;
  import cap_pkg::*;
  // ****************************************
  // Signals
  // ****************************************
  logic sys_clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic [7:0] addr_in = 8'h00;
  logic [7:0] wdata_in = 8'h00;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic timer_ovf_in = 1'b0;
  logic ext_count_pin_in = 1'b0;
  logic [7:0] rdata_out;
  logic [4:0] pins;
  logic irq_out;
  logic wd_reset_out;
  logic [7:0] edges [5];
  int errors = 0;
  int check_count = 0;
  int cycles = 0;
  int wd_hits = 0;
  logic [7:0] zero_addrs [9] = '{8'hD8, 8'hD9, 8'hDA, 8'hDE, 8'hE9, 8'hF9, 8'hC0, 8'hC1, 8'h00};
  always #25 sys_clk_in = ~sys_clk_in;
  cap_counter_array cap_counter_array_inst (.sys_clk_in, .reset_n_in, .addr_in, .wdata_in,
    .wr_in, .rd_in, .rdata_out, .timer_ovf_in, .ext_count_pin_in,
    .module_output_pin_out(pins), .irq_out, .wd_reset_out);
  cap_pin_load cap_pin_load_inst (.sys_clk_in, .reset_n_in, .pins_in(pins), .edges_out(edges));
  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge sys_clk_in);
    wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic [7:0] m);
    @(posedge sys_clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge sys_clk_in);
    rd_in <= 1'b0;
    #1 chk(rdata_out & m, exp);
  endtask
  // Count pulses from the timer source, then let pins settle
  task automatic step(input int n);
    repeat (n) begin
      @(posedge sys_clk_in);
      timer_ovf_in <= 1'b1;
      @(posedge sys_clk_in);
      timer_ovf_in <= 1'b0;
    end
    repeat (6) @(posedge sys_clk_in);
    #1;
  endtask
  task automatic wd_check(input logic [7:0] exp);
    repeat (8) @(posedge sys_clk_in);
    #1 chk(8'(wd_hits), exp);
    wd_hits = 0;
  endtask
  task automatic complete_run();
    $display("Checks: %0d, errors: %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Reset pulse cycles and run ceiling, sampled mid-cycle where outputs are settled
  always @(negedge sys_clk_in) begin
    wd_hits += int'(wd_reset_out === 1'b1);
    cycles++;
    if (cycles == 20000) begin
      errors++;
      complete_run();
    end
  end
  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    repeat (12) @(posedge sys_clk_in);
    reset_n_in <= 1'b1;
    foreach (zero_addrs[i]) rd(zero_addrs[i], 8'h00, 8'hFF);
    wr(`CAP_ADDR_DLO0, 8'h05);
    wr(`CAP_ADDR_DLO0 + 8'h01, 8'h07);
    wr(`CAP_ADDR_MODE0, 8'h49);
    wr(`CAP_ADDR_MODE0 + 8'h01, 8'h4C);
    wr(`CAP_ADDR_IRQ_MASK, 8'h01);
    wr(`CAP_ADDR_COUNTER_MODE_REG, 8'h04);
    wr(`CAP_ADDR_CTRL, 8'h40);
    step(4);
    rd(`CAP_ADDR_CTRL, 8'h40, 8'hFF);
    chk(8'(pins), 8'h00);
    step(1);
    rd(`CAP_ADDR_CTRL, 8'h41, 8'hFF);
    chk(8'(irq_out), 8'h01);
    step(2);
    rd(`CAP_ADDR_CTRL, 8'h43, 8'hFF);
    chk(8'(pins), 8'h02);
    chk(edges[1], 8'h01);
    rd(`CAP_ADDR_IRQ_STAT, 8'h01, 8'h01);
    rd(`CAP_ADDR_IRQ_MASK, 8'h01, 8'hFF);
    // Flag with its enable still set raises the status again
    chk(8'(irq_out), 8'h01);
    wr(`CAP_ADDR_CTRL, 8'h00);
    step(3);
    rd(`CAP_ADDR_CNT_LO, 8'h07, 8'hFF);
    rd(`CAP_ADDR_CTRL, 8'h00, 8'hFF);
    // Module 2 as PWM, low byte below duty
    wr(`CAP_ADDR_DHI0 + 8'h02, 8'h40);
    wr(`CAP_ADDR_DLO0 + 8'h02, 8'h80);
    wr(`CAP_ADDR_MODE0 + 8'h02, 8'h42);
    step(0);
    chk(8'(pins), 8'h02);
    wr(`CAP_ADDR_CNT_LO, 8'h80);
    step(0);
    chk(8'(pins), 8'h06);
    wr(`CAP_ADDR_CNT_LO, 8'hFF);
    wr(`CAP_ADDR_CTRL, 8'h40);
    step(1);
    chk(8'(pins), 8'h02);
    rd(`CAP_ADDR_DLO0 + 8'h02, 8'h40, 8'hFF);
    // Watchdog armed, module 3 matches first
    wr(`CAP_ADDR_DHI0 + 8'h03, 8'h01);
    wr(`CAP_ADDR_DLO0 + 8'h03, 8'h03);
    wr(`CAP_ADDR_MODE0 + 8'h03, 8'h48);
    wr(`CAP_ADDR_COUNTER_MODE_REG, 8'h44);
    step(3);
    wd_check(8'h00);
    rd(`CAP_ADDR_CTRL, 8'h08, 8'h18);
    wr(`CAP_ADDR_DHI0 + 8'h04, 8'h01);
    wr(`CAP_ADDR_DLO0 + 8'h04, 8'h05);
    wr(`CAP_ADDR_MODE0 + 8'h04, 8'h48);
    step(2);
    wd_check(8'(`CAP_WD_PULSE_CYC));
    wr(`CAP_ADDR_COUNTER_MODE_REG, 8'h04);
    wr(`CAP_ADDR_DLO0 + 8'h04, 8'h08);
    step(3);
    wd_check(8'h00);
    rd(`CAP_ADDR_CTRL, 8'h10, 8'h10);
    wr(`CAP_ADDR_COUNTER_MODE_REG, 8'h44);
    wr(`CAP_ADDR_DLO0 + 8'h04, 8'h0A);
    step(2);
    wd_check(8'(`CAP_WD_PULSE_CYC));
    // Sixteen-bit wrap raises the overflow flag
    wr(`CAP_ADDR_CTRL, 8'h40);
    rd(`CAP_ADDR_IRQ_STAT, 8'h01, 8'h01);
    chk(8'(irq_out), 8'h00);
    wr(`CAP_ADDR_IRQ_MASK, 8'h02);
    wr(`CAP_ADDR_COUNTER_MODE_REG, 8'h05);
    wr(`CAP_ADDR_CNT_HI, 8'hFF);
    wr(`CAP_ADDR_CNT_LO, 8'hFF);
    step(1);
    rd(`CAP_ADDR_CTRL, 8'h80, 8'h80);
    chk(8'(irq_out), 8'h01);
    rd(`CAP_ADDR_IRQ_MASK, 8'h02, 8'h03);
    // External pin as count source, two rising edges
    wr(`CAP_ADDR_COUNTER_MODE_REG, 8'h06);
    repeat (2) begin
      @(posedge sys_clk_in);
      ext_count_pin_in <= 1'b1;
      repeat (6) @(posedge sys_clk_in);
      ext_count_pin_in <= 1'b0;
      repeat (6) @(posedge sys_clk_in);
    end
    rd(`CAP_ADDR_CNT_LO, 8'h02, 8'hFF);
    complete_run();
  end
endmodule

// ### cap_map.svh
`ifndef CAP_MAP_SVH
`define CAP_MAP_SVH
// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define CAP_ADDR_CTRL 8'hD8
`define CAP_ADDR_COUNTER_MODE_REG 8'hD9
`define CAP_ADDR_MODE0 8'hDA
`define CAP_ADDR_CNT_LO 8'hE9
`define CAP_ADDR_CNT_HI 8'hF9
`define CAP_ADDR_DLO0 8'hEA
`define CAP_ADDR_DHI0 8'hFA
`define CAP_ADDR_IRQ_STAT 8'hC0
`define CAP_ADDR_IRQ_MASK 8'hC1
// ****************************************
// Field positions
// ****************************************
`define CAP_CTRL_OVF 7
`define CAP_CTRL_RUN 6
`define CAP_COUNTER_MODE_REG_WATCHDOG_ENABLE_BIT 6
`define CAP_COUNTER_MODE_REG_OVF_IE 0
`define CAP_MODE_ECOM 6
`define CAP_MODE_MAT 3
`define CAP_MODE_TOG 2
`define CAP_MODE_PWM 1
`define CAP_MODE_IE 0
// ****************************************
// Reset values and counts
// ****************************************
`define CAP_RST_BYTE 8'h00
`define CAP_WD_MODULE 4
`define CAP_WD_PULSE_NS 200
`define CAP_CLK_NS 50
`define CAP_WD_PULSE_CYC ((`CAP_WD_PULSE_NS + `CAP_CLK_NS - 1) / `CAP_CLK_NS)
`endif

// ### cap_module.sv
`timescale 1ns/1ps
`include "cap_map.svh"
// One compare module: match, toggle, pwm
module cap_module
  import cap_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  input wire logic [7:0] mode_in,
  input wire logic [15:0] count_in,
  input wire logic [15:0] next_count_in,
  input wire logic step_in,
  input wire logic [7:0] reload_in,
  input wire logic wr_active_in,
  input wire logic [7:0] wdata_in,
  output logic match_out,
  output logic [7:0] active_duty_out,
  output logic pin_out
);
  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [7:0] duty;
    logic pin;
  } cap_mod_state_t;
  cap_mod_state_t st;
  cap_mod_state_t next_st;
  logic cmp_on;
  logic pwm_on;
  logic [7:0] pwm_lo; // Counter low byte the pwm pin follows
  // Match, toggle and pwm output
  always_comb begin
    next_st = st;
    // A stopped counter keeps its byte, a stepping one shows the new byte
    pwm_lo = step_in ? next_count_in[7:0] : count_in[7:0];
    cmp_on = mode_in[`CAP_MODE_ECOM] && mode_in[`CAP_MODE_MAT];
    pwm_on = mode_in[`CAP_MODE_ECOM] && mode_in[`CAP_MODE_PWM];
    // Match when counter lands on compare value
    match_out = cmp_on && step_in && (next_count_in == {reload_in, st.duty});
    if (wr_active_in) begin
      next_st.duty = wdata_in;
    end else if (pwm_on && step_in && count_in[7:0] == 8'hFF) begin
      next_st.duty = reload_in;
    end
    if (pwm_on) begin
      // Low below duty, high at or above
      next_st.pin = (pwm_lo >= next_st.duty);
    end else if (match_out && mode_in[`CAP_MODE_TOG]) begin
      next_st.pin = !st.pin;
    end
  end
  assign active_duty_out = st.duty;
  assign pin_out = st.pin;
  // Register
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
endmodule

// ### cap_pin_load.sv
`timescale 1ns/1ps
// Load on the module pins: counts rising edges per pin
module cap_pin_load #(
  parameter int N = 5
) (
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  input wire logic [N-1:0] pins_in,
  output logic [7:0] edges_out [N]
);
  logic [N-1:0] last; // Pin levels one cycle ago
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      last <= '0;
      foreach (edges_out[i]) edges_out[i] <= 8'h00;
    end else begin
      last <= pins_in;
      foreach (edges_out[i]) edges_out[i] <= edges_out[i] + 8'(pins_in[i] && !last[i]);
    end
  end
endmodule

// ### cap_pkg.sv
package cap_pkg;
  // Count pulse sources
  typedef enum logic [1:0] {
    CAP_SRC_DIV6 = 2'h0,
    CAP_SRC_DIV2 = 2'h1,
    CAP_SRC_TMR = 2'h2,
    CAP_SRC_EXT = 2'h3
  } cap_src_t;
  typedef logic [7:0] cap_byte_t;
endpackage

// ### cap_pulse_gen.sv
`timescale 1ns/1ps
`include "cap_map.svh"
// Count pulse selector and divider
module cap_pulse_gen
  import cap_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  input wire cap_pkg::cap_src_t src_in,
  input wire logic timer_ovf_in,
  input wire logic ext_pin_in,
  output logic pulse_out
);
  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [2:0] div;
    logic [2:0] sync;
    logic ext_last;
  } cap_pg_state_t;
  cap_pg_state_t st;
  cap_pg_state_t next_st;
  logic ext_edge;
  // Next state and pulse
  always_comb begin
    next_st = st;
    next_st.div = (st.div >= 3'h5) ? 3'h0 : 3'(st.div + 3'h1);
    next_st.sync = {st.sync[1:0], ext_pin_in};
    // Change counts once stages two and three agree
    if (st.sync[2] == st.sync[1]) begin
      next_st.ext_last = st.sync[2];
    end
    ext_edge = (st.sync[2] == st.sync[1]) && st.sync[2] && !st.ext_last;
    unique case (src_in)
      CAP_SRC_DIV6: pulse_out = (st.div == 3'h5);
      CAP_SRC_DIV2: pulse_out = st.div[0];
      CAP_SRC_TMR: pulse_out = timer_ovf_in;
      CAP_SRC_EXT: pulse_out = ext_edge;
    endcase
  end
  // Register
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
endmodule
